// ---- rtl/lgm_pkg.sv ----
// How it works
// - Control word bits 7:6 pick normal, digital loopback, analog loopback or powerdown.
// - Bits 5:3 give receive gain of minus n decibels with trim pin low.
// - Bits 2:0 give transmit gain of plus n decibels, zero to seven.
// - Trim pin high adds half a decibel receive attenuation; transmit unchanged.
`default_nettype none

package lgm_pkg;

    // =====================================================================
    // Control word layout.
    // =====================================================================
    localparam int unsigned WORD_BITS   = 8;
    localparam int unsigned FUNC_HI     = 7;
    localparam int unsigned FUNC_LO     = 6;
    localparam int unsigned RX_GAIN_HI  = 5;
    localparam int unsigned RX_GAIN_LO  = 3;
    localparam int unsigned TX_GAIN_HI  = 2;
    localparam int unsigned TX_GAIN_LO  = 0;
    localparam int unsigned GAIN_BITS   = 3;
    localparam int unsigned HALF_DB_BITS = 4;

    // Value taken by the control word at reset.
    localparam logic [7:0] CONTROL_RESET = 8'h00;

    // Bit counter width for the serial receiver.
    localparam int unsigned COUNT_BITS  = 4;
    localparam logic [3:0]  COUNT_LAST  = 4'h7;
    localparam logic [3:0]  COUNT_ZERO  = 4'h0;
    localparam logic [3:0]  COUNT_ONE   = 4'h1;

    // =====================================================================
    // Special function codes.
    // =====================================================================
    typedef enum logic [1:0] {
        LGM_NORMAL,
        LGM_DIGITAL_LOOP,
        LGM_ANALOG_LOOP,
        LGM_POWERDOWN
    } lgm_function_type;

    // Receive attenuation in half decibel units: two per step plus the trim.
    function automatic logic [3:0] lgm_rx_half_db(input logic [2:0] step, input logic trim);
        lgm_rx_half_db = {step, trim};
    endfunction

endpackage

`default_nettype wire

// ---- rtl/lgm_deserializer.sv ----
`timescale 1ns/1ps
`default_nettype none

// =========================================================================
// Serial control receiver: collects eight bits, most significant first.
// =========================================================================
module lgm_deserializer #(
    parameter int unsigned WIDTH = lgm_pkg::WORD_BITS
) (
    input  wire logic             mclk,
    input  wire logic             rst_b,
    input  wire logic             control_serial_input,
    input  wire logic             bit_strobe,
    input  wire logic             word_start,
    output logic                  word_valid,
    output logic [WIDTH-1:0]      word
);

    logic [lgm_pkg::COUNT_BITS-1:0] count;
    logic [WIDTH-1:0]               shift;

    // A start strobe always begins a fresh word, so a torn word cannot load.
    wire logic [lgm_pkg::COUNT_BITS-1:0] base_count = word_start ? lgm_pkg::COUNT_ZERO : count;
    wire logic                           last_bit   = bit_strobe && (base_count == lgm_pkg::COUNT_LAST);
    wire logic [WIDTH-1:0]               next_shift = {shift[WIDTH-2:0], control_serial_input};

    // Shift in one bit per strobe and count the bits of the word.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            count <= lgm_pkg::COUNT_ZERO;
            shift <= '0;
        end else if (bit_strobe) begin
            shift <= next_shift;
            count <= last_bit ? lgm_pkg::COUNT_ZERO : base_count + lgm_pkg::COUNT_ONE;
        end else if (word_start) begin
            count <= lgm_pkg::COUNT_ZERO;
        end
    end

    // Hand the complete word on with a one cycle pulse.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            word_valid <= 1'b0;
            word       <= '0;
        end else begin
            word_valid <= last_bit;
            if (last_bit) begin
                word <= next_shift;
            end
        end
    end

endmodule

`default_nettype wire

// ---- rtl/lgm_control.sv ----
`timescale 1ns/1ps
`default_nettype none

// =========================================================================
// Function and gain control register of the line interface.
// =========================================================================
module lgm_control (
    input  wire logic                      mclk,
    input  wire logic                      rst_b,
    input  wire logic                      control_serial_input,
    input  wire logic                      control_bit_strobe,
    input  wire logic                      control_word_start,
    input  wire logic                      receive_trim_select_pin,
    output lgm_pkg::lgm_function_type      special_function,
    output logic                           digital_loopback,
    output logic                           analog_loopback,
    output logic                           powerdown,
    output logic [2:0]                     rx_gain_step,
    output logic [3:0]                     rx_atten_half_db,
    output logic [2:0]                     tx_gain_step,
    output logic                           word_loaded
);

    // =====================================================================
    // Serial word reception.
    // =====================================================================
    logic       rx_word_valid;
    logic [7:0] rx_word;

    lgm_deserializer #(
        .WIDTH (lgm_pkg::WORD_BITS)
    ) u_deser (
        .mclk                 (mclk),
        .rst_b                (rst_b),
        .control_serial_input (control_serial_input),
        .bit_strobe           (control_bit_strobe),
        .word_start           (control_word_start),
        .word_valid           (rx_word_valid),
        .word                 (rx_word)
    );

    // =====================================================================
    // Held control word.
    // =====================================================================
    logic [7:0] function_and_gain_control;

    // The word changes only when a complete new word arrives.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            function_and_gain_control <= lgm_pkg::CONTROL_RESET;
        end else if (rx_word_valid) begin
            function_and_gain_control <= rx_word;
        end
    end

    // =====================================================================
    // Field decoding.
    // =====================================================================
    wire logic [1:0] func_field = function_and_gain_control[lgm_pkg::FUNC_HI:lgm_pkg::FUNC_LO];
    wire logic [2:0] rx_field   = function_and_gain_control[lgm_pkg::RX_GAIN_HI:lgm_pkg::RX_GAIN_LO];
    wire logic [2:0] tx_field   = function_and_gain_control[lgm_pkg::TX_GAIN_HI:lgm_pkg::TX_GAIN_LO];

    wire lgm_pkg::lgm_function_type next_function = lgm_pkg::lgm_function_type'(func_field);
    wire logic       next_digital = (next_function == lgm_pkg::LGM_DIGITAL_LOOP);
    wire logic       next_analog  = (next_function == lgm_pkg::LGM_ANALOG_LOOP);
    wire logic       next_down    = (next_function == lgm_pkg::LGM_POWERDOWN);
    // Trim pin high adds one half decibel step to the receive side only.
    wire logic [3:0] next_rx_half = lgm_pkg::lgm_rx_half_db(rx_field, receive_trim_select_pin);

    // =====================================================================
    // Registered outputs.
    // =====================================================================
    // All outputs but word_loaded follow the held word one cycle later; rx_atten_half_db also follows the trim pin.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            special_function <= lgm_pkg::LGM_NORMAL;
            digital_loopback <= 1'b0;
            analog_loopback  <= 1'b0;
            powerdown        <= 1'b0;
            rx_gain_step     <= '0;
            rx_atten_half_db <= '0;
            tx_gain_step     <= '0;
            word_loaded      <= 1'b0;
        end else begin
            special_function <= next_function;
            digital_loopback <= next_digital;
            analog_loopback  <= next_analog;
            powerdown        <= next_down;
            rx_gain_step     <= rx_field;
            rx_atten_half_db <= next_rx_half;
            tx_gain_step     <= tx_field;
            word_loaded      <= rx_word_valid;
        end
    end

    // =====================================================================
    // Checks.
    // =====================================================================
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    // Cycles after a load before the decoded outputs must stand still.
    localparam logic [lgm_pkg::COUNT_BITS-1:0] QUIET_SETTLE = 4'h2;

    logic [lgm_pkg::COUNT_BITS-1:0] quiet_cycles;
    wire logic                      quiet_top = (quiet_cycles == '1);

    // Counts cycles since the last complete word and saturates at its top value.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            quiet_cycles <= lgm_pkg::COUNT_ZERO;
        end else if (rx_word_valid) begin
            quiet_cycles <= lgm_pkg::COUNT_ZERO;
        end else if (!quiet_top) begin
            quiet_cycles <= quiet_cycles + lgm_pkg::COUNT_ONE;
        end
    end

    // A new word reaches the function code two cycles after it is complete.
    a_func_decode: assert property (
        rx_word_valid |-> ##2 special_function == lgm_pkg::lgm_function_type'($past(rx_word[7:6], 2))
    )
        else $error("Special function does not follow bits 7:6.");

    // Each function flag follows the code held one cycle earlier.
    a_loop_flags: assert property (
        (digital_loopback == ($past(func_field) == lgm_pkg::LGM_DIGITAL_LOOP))
        && (analog_loopback == ($past(func_field) == lgm_pkg::LGM_ANALOG_LOOP))
        && (powerdown == ($past(func_field) == lgm_pkg::LGM_POWERDOWN))
    )
        else $error("Function flags disagree with the held function code.");

    // At most one of the function flags is raised at a time.
    a_flag_onehot: assert property (
        $onehot0({digital_loopback, analog_loopback, powerdown})
    )
        else $error("More than one function flag is raised.");

    // The receive step follows bits 5:3 of the new word.
    a_rx_gain: assert property (
        rx_word_valid |-> ##2 rx_gain_step == $past(rx_word[5:3], 2)
    )
        else $error("Receive gain step does not follow bits 5:3.");

    // The transmit step follows bits 2:0 of the new word.
    a_tx_gain: assert property (
        rx_word_valid |-> ##2 tx_gain_step == $past(rx_word[2:0], 2)
    )
        else $error("Transmit gain step does not follow bits 2:0.");

    // The attenuation is two half steps per decibel plus the trim.
    a_rx_trim: assert property (
        ##1 rx_atten_half_db == {$past(rx_field), $past(receive_trim_select_pin)}
    )
        else $error("Receive attenuation ignores the trim pin.");

    // Any trim pin change moves the attenuation one cycle later.
    a_trim_step: assert property (
        $changed(receive_trim_select_pin) |=> $changed(rx_atten_half_db)
    )
        else $error("Trim pin change did not reach the attenuation.");

    // The trim pin never touches the transmit gain.
    a_tx_no_trim: assert property (
        $changed(receive_trim_select_pin) && !rx_word_valid && !word_loaded |=> $stable(tx_gain_step)
    )
        else $error("Trim pin disturbed the transmit gain.");

    // The trim pin never touches the function or the receive step.
    a_trim_keeps_function: assert property (
        $changed(receive_trim_select_pin) && !rx_word_valid && !word_loaded
        |=> $stable(special_function) && $stable(rx_gain_step)
    )
        else $error("Trim pin disturbed the function or the receive step.");

    // The held word changes only on a complete new word.
    a_word_hold: assert property (
        !rx_word_valid [*2] |-> $stable(function_and_gain_control) [*2]
    )
        else $error("Control word changed without a new word.");

    // Once settled, the decoded outputs stand until the next word.
    a_quiet_hold: assert property (
        (quiet_cycles >= QUIET_SETTLE)
        |-> $stable(special_function) && $stable(rx_gain_step) && $stable(tx_gain_step)
    )
        else $error("Decoded outputs moved without a new word.");

    // A complete word is loaded one cycle after it arrives.
    a_load_pulse: assert property (
        rx_word_valid |=> word_loaded ##1 function_and_gain_control == $past(rx_word, 2)
    )
        else $error("Received word not loaded.");

    // The load indication is a single cycle pulse.
    a_loaded_pulse: assert property (
        word_loaded |=> !word_loaded
    )
        else $error("Load indication stayed high.");

    // A word needs eight strobes, so two words are at least eight cycles apart.
    a_word_spacing: assert property (
        rx_word_valid |=> !rx_word_valid [*7]
    )
        else $error("Words completed closer than eight strobes.");

    // A word completes only on a strobed bit.
    a_valid_strobe: assert property (
        rx_word_valid |-> $past(control_bit_strobe)
    )
        else $error("Word completed without a bit strobe.");

    // Main scenarios: each special function but normal, the deepest attenuation and a trim step.
    c_powerdown:  cover property (rx_word_valid ##2 powerdown);
    // Digital loopback selected by a new word.
    c_dig_loop:   cover property (rx_word_valid ##2 digital_loopback);
    // Analog loopback selected by a new word.
    c_ana_loop:   cover property (rx_word_valid ##2 analog_loopback);
    // Deepest receive attenuation with the trim raised.
    c_trim_max:   cover property (rx_atten_half_db == 4'hF);
    // Trim pin change seen at the attenuation.
    c_trim_step:  cover property ($changed(receive_trim_select_pin) ##1 $changed(rx_atten_half_db));

endmodule

`default_nettype wire

// ---- verif/lgm_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// =========================================================================
// Line-card controller model: sends control bits on the serial stream.
// =========================================================================
module lgm_ctrl_model (
    input  wire logic mclk,
    output logic      serial_data,
    output logic      bit_strobe,
    output logic      word_start
);
    // Idle stream is quiet at time zero.
    initial begin
        serial_data = 1'b0;
        bit_strobe  = 1'b0;
        word_start  = 1'b0;
    end

    // Sends the first n bits of w, most significant first, one per cycle.
    task automatic send(input logic [7:0] w, input int n);
        int k;
        for (k = 0; k < n; k++) begin
            @(posedge mclk);
            #1;
            word_start  = (k == 0);
            bit_strobe  = 1'b1;
            serial_data = w[7-k];
        end
        @(posedge mclk);
        #1;
        bit_strobe  = 1'b0;
        word_start  = 1'b0;
        serial_data = ~serial_data; // Stale data is flipped so it is never mistaken for a bit.
    endtask
endmodule

`default_nettype wire

// ---- verif/line_interface_gain_mode_control_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

// =========================================================================
// Bench for the function and gain control register.
// =========================================================================
module line_interface_gain_mode_control_tb_top;
    logic                      mclk, rst_b, sdata, strobe, start, trim, dl, al, pd, wl;
    lgm_pkg::lgm_function_type func;
    logic [2:0]                rxs, txs, i;
    logic [3:0]                att;
    int                        n_mismatch, n_compared, n_loads, cycles;

    // Clock of 4 ns period.
    initial mclk = 1'b0;
    always #2 mclk = ~mclk;

    lgm_ctrl_model ctl (.mclk(mclk), .serial_data(sdata), .bit_strobe(strobe), .word_start(start));

    lgm_control uut (
        .mclk(mclk), .rst_b(rst_b), .control_serial_input(sdata), .control_bit_strobe(strobe),
        .control_word_start(start), .receive_trim_select_pin(trim), .special_function(func),
        .digital_loopback(dl), .analog_loopback(al), .powerdown(pd), .rx_gain_step(rxs),
        .rx_atten_half_db(att), .tx_gain_step(txs), .word_loaded(wl)
    );

    // Counts load pulses and cuts a hung run short.
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (rst_b === 1'b1 && wl === 1'b1) n_loads <= n_loads + 1;
        if (cycles == 3000) begin
            n_mismatch = n_mismatch + 1;
            test_done();
        end
    end

    // Compares one value and reports a mismatch.
    task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Checks every output but word_loaded against the word w and trim level t.
    task automatic chk_all(input logic [7:0] w, input logic t);
        chk("function", {2'h0, w[7:6]}, {2'h0, func});
        chk("digital_loopback", {3'h0, w[7:6] == 2'h1}, {3'h0, dl});
        chk("analog_loopback", {3'h0, w[7:6] == 2'h2}, {3'h0, al});
        chk("powerdown", {3'h0, w[7:6] == 2'h3}, {3'h0, pd});
        chk("rx_gain_step", {1'h0, w[5:3]}, {1'h0, rxs});
        chk("rx_atten", {w[5:3], t}, att);
        chk("tx_gain_step", {1'h0, w[2:0]}, {1'h0, txs});
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Main sequence of writes and checks.
    initial begin
        {n_mismatch, n_compared, n_loads, cycles} = '0;
        rst_b = 1'b0;
        trim  = 1'b0;
        repeat (16) @(posedge mclk);
        #1 rst_b = 1'b1;
        chk_all(lgm_pkg::CONTROL_RESET, 1'b0);
        for (int k = 0; k < 8; k++) begin
            i = k[2:0];
            trim = i[0];
            ctl.send({i[1:0], i, ~i}, 8);
            repeat (2) @(posedge mclk);
            #1 chk_all({i[1:0], i, ~i}, i[0]);
        end
        // A restarted word drops the earlier partial bits.
        ctl.send(8'hFF, 5);
        repeat (3) @(posedge mclk);
        #1 chk_all(8'hF8, 1'b1);
        ctl.send(8'h9A, 8);
        repeat (2) @(posedge mclk);
        #1 chk_all(8'h9A, 1'b1);
        trim = 1'b0;
        @(posedge mclk);
        #1 chk_all(8'h9A, 1'b0);
        repeat (30) @(posedge mclk);
        #1 chk_all(8'h9A, 1'b0);
        chk("loads", 4'h9, n_loads[3:0]);
        test_done();
    end
endmodule

`default_nettype wire
